/* File: design/compact_timer.sv */
`timescale 1ns/1ps
module compact_timer (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic timer_tick,
    input wire logic counter_on,
    input wire logic mode_select_high,
    input wire logic mode_select_low,
    input wire logic clear_select,
    input wire logic output_action_high,
    input wire logic output_action_low,
    input wire logic initial_level,
    input wire logic output_invert,
    input wire logic period_duty_swap,
    input wire logic [2:0] period_code,
    input wire logic [9:0] compare_a_value,
    input wire logic flag_clear_a,
    input wire logic flag_clear_p,
    output logic compare_a_flag,
    output logic period_match_flag,
    output logic timer_out,
    output logic timer_out_enable,
    output logic [9:0] count_value
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [9:0] count;
    logic [9:0] next_count;
    logic on_seen;
    logic next_on_seen;
    logic pin;
    logic next_pin;
    logic next_compare_a_flag;
    logic next_period_match_flag;
    logic next_timer_out;
    logic next_timer_out_enable;
    logic [1:0] action;
    logic [10:0] p_len;
    logic [10:0] duty;
    logic [10:0] period;
    logic pwm_level;
    logic rise;
    logic is_pwm;
    logic is_cmp;
    logic pwm_end;
    logic clr;
    logic set_a;
    logic set_p;
    logic reach_a;
    compact_timer_pkg::mode_t mode;

    timer_match_if m ();

    assign m.count = count;
    assign m.period_code = period_code;
    assign m.compare_a_value = compare_a_value;

    timer_comparators u_comp (
        .m(m)
    );

    pwm_shaper u_pwm (
        .duty(duty),
        .period(period),
        .count(count),
        .action(action),
        .initial_level(initial_level),
        .output_invert(output_invert),
        .level(pwm_level)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    // Period code 000 stands for the full 1024-tick span
    function automatic logic [10:0] code_len(input logic [2:0] code);
        code_len = (code == 3'h0) ? compact_timer_pkg::PERIOD_FULL :
            {1'b0, code, 7'h00};
    endfunction

    always_comb begin
        mode = compact_timer_pkg::mode_t'({mode_select_high,
            mode_select_low});
        action = {output_action_high, output_action_low};
        is_pwm = (mode == compact_timer_pkg::MODE_PWM);
        is_cmp = (mode == compact_timer_pkg::MODE_COMPARE);
        rise = counter_on && !on_seen;
        p_len = code_len(period_code);
        if (period_duty_swap) begin
            period = {1'b0, compare_a_value};
            duty = p_len;
        end else begin
            period = p_len;
            duty = {1'b0, compare_a_value};
        end
        // Last count of a PWM period; the clear starts the next one
        pwm_end = ({1'b0, count} + 11'h001 >= period) || m.at_max;
        // PWM takes the A match on the tick that brings the counter onto
        // compare A, so an A-set period end still raises its flag
        reach_a = ({1'b0, count} + 11'h001) == {1'b0, compare_a_value};
        set_a = 1'b0;
        set_p = 1'b0;
        clr = 1'b0;
        case (mode)
            compact_timer_pkg::MODE_PWM: begin
                set_a = reach_a;
                set_p = m.match_p;
                clr = pwm_end;
            end
            compact_timer_pkg::MODE_COMPARE,
            compact_timer_pkg::MODE_TIMER: begin
                if (clear_select) begin
                    // Compare A of zero lets the counter wrap at 3FF
                    set_a = m.match_a && (compare_a_value != 10'h000);
                    clr = set_a || m.at_max;
                end else begin
                    set_a = m.match_a;
                    set_p = m.match_p;
                    clr = m.match_p || m.at_max;
                end
            end
            default: begin
                set_a = 1'b0;
            end
        endcase
        set_a = set_a && timer_tick && counter_on;
        set_p = set_p && timer_tick && counter_on;

        next_on_seen = counter_on;
        next_count = count;
        if (rise) begin
            next_count = compact_timer_pkg::COUNT_RESET;
        end else if (counter_on && timer_tick) begin
            next_count = clr ? compact_timer_pkg::COUNT_RESET :
                count + 10'h001;
        end

        // Flag set wins over a clear in the same cycle
        next_compare_a_flag = set_a || (compare_a_flag && !flag_clear_a);
        next_period_match_flag = set_p ||
            (period_match_flag && !flag_clear_p);

        next_pin = pin;
        if (is_cmp && rise) begin
            next_pin = initial_level;
        end else if (is_cmp && set_a) begin
            case (action)
                compact_timer_pkg::ACT_LOW: next_pin = 1'b0;
                compact_timer_pkg::ACT_HIGH: next_pin = 1'b1;
                compact_timer_pkg::ACT_TOGGLE: next_pin = !pin;
                default: next_pin = pin;
            endcase
        end

        next_timer_out = is_pwm ? pwm_level : (pin ^ output_invert);
        // Timer mode leaves the pin to general I/O
        next_timer_out_enable = is_pwm || is_cmp;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count <= compact_timer_pkg::COUNT_RESET;
            on_seen <= 1'b0;
            pin <= compact_timer_pkg::PIN_RESET;
            compare_a_flag <= 1'b0;
            period_match_flag <= 1'b0;
            timer_out <= compact_timer_pkg::PIN_RESET;
            timer_out_enable <= 1'b0;
            count_value <= compact_timer_pkg::COUNT_RESET;
        end else begin
            count <= next_count;
            on_seen <= next_on_seen;
            pin <= next_pin;
            compare_a_flag <= next_compare_a_flag;
            period_match_flag <= next_period_match_flag;
            timer_out <= next_timer_out;
            timer_out_enable <= next_timer_out_enable;
            count_value <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_rise_zero;
        @(posedge clock) disable iff (sys_rst)
        (counter_on && !on_seen) |=> (count == 10'h000);
    endproperty
    a_rise_zero: assert property (p_rise_zero)
        else $error("counter not zeroed on enable rise");

    property p_hold_off;
        @(posedge clock) disable iff (sys_rst)
        (!counter_on && on_seen) ##1 !counter_on |-> $stable(count);
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("counter moved while off");

    property p_no_pflag;
        @(posedge clock) disable iff (sys_rst)
        (!is_pwm && clear_select && !period_match_flag && !flag_clear_p)
        |=> !period_match_flag;
    endproperty
    a_no_pflag: assert property (p_no_pflag)
        else $error("period flag set with clear select high");

    property p_a_zero;
        @(posedge clock) disable iff (sys_rst)
        (!is_pwm && clear_select && compare_a_value == 10'h000 &&
        counter_on && on_seen && timer_tick && !compare_a_flag &&
        !flag_clear_a) |=> !compare_a_flag;
    endproperty
    a_a_zero: assert property (p_a_zero)
        else $error("A flag with zero compare A in clear-A mode");

    property p_wrap;
        @(posedge clock) disable iff (sys_rst)
        (!is_pwm && counter_on && on_seen && timer_tick &&
        count == 10'h3ff) |=> (count == 10'h000);
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("counter did not wrap at maximum");

    property p_pin_init;
        @(posedge clock) disable iff (sys_rst)
        (is_cmp && counter_on && !on_seen) |=> (pin == $past(initial_level));
    endproperty
    a_pin_init: assert property (p_pin_init)
        else $error("pin not restored to initial level");

    property p_pin_only_a;
        @(posedge clock) disable iff (sys_rst)
        (is_cmp && !set_a && on_seen) |=> $stable(pin);
    endproperty
    a_pin_only_a: assert property (p_pin_only_a)
        else $error("pin changed without A match");

    property p_timer_free;
        @(posedge clock) disable iff (sys_rst)
        (mode == compact_timer_pkg::MODE_TIMER) |=> !timer_out_enable;
    endproperty
    a_timer_free: assert property (p_timer_free)
        else $error("pin driven in timer mode");

    property p_force_active;
        @(posedge clock) disable iff (sys_rst)
        (is_pwm && action == compact_timer_pkg::PWM_FORCE_ACTIVE)
        |=> (timer_out == ($past(initial_level) ^ $past(output_invert)));
    endproperty
    a_force_active: assert property (p_force_active)
        else $error("forced active level wrong");

    property p_p_clear;
        @(posedge clock) disable iff (sys_rst)
        (is_cmp && !clear_select && period_code != 3'h0 && counter_on &&
        on_seen && timer_tick &&
        ({1'b0, count} + 11'h001 == code_len(period_code)))
        |=> (period_match_flag && count == 10'h000);
    endproperty
    a_p_clear: assert property (p_p_clear)
        else $error("period match did not clear counter and set flag");

    property p_pwm_period;
        @(posedge clock) disable iff (sys_rst)
        (is_pwm && !period_duty_swap && counter_on && on_seen && timer_tick
        && ({1'b0, count} + 11'h001 == code_len(period_code)))
        |=> (count == 10'h000);
    endproperty
    a_pwm_period: assert property (p_pwm_period)
        else $error("PWM period did not end at the period code");

    property p_full_duty;
        @(posedge clock) disable iff (sys_rst)
        (is_pwm && action == compact_timer_pkg::PWM_WAVE && duty >= period)
        |=> (timer_out == ($past(initial_level) ^ $past(output_invert)));
    endproperty
    a_full_duty: assert property (p_full_duty)
        else $error("full duty output not held active");

    property p_force_inactive;
        @(posedge clock) disable iff (sys_rst)
        (is_pwm && action == compact_timer_pkg::PWM_FORCE_INACTIVE)
        |=> (timer_out != ($past(initial_level) ^ $past(output_invert)));
    endproperty
    a_force_inactive: assert property (p_force_inactive)
        else $error("forced inactive level wrong");
endmodule

/* File: design/pwm_shaper.sv */
`timescale 1ns/1ps
module pwm_shaper (
    input wire logic [10:0] duty,
    input wire logic [10:0] period,
    input wire logic [9:0] count,
    input wire logic [1:0] action,
    input wire logic initial_level,
    input wire logic output_invert,
    output logic level
);
    logic active;
    logic raw;

    // ------------------------------------------------------------
    // Waveform
    // ------------------------------------------------------------
    // Duty at or above the period keeps the output active all period
    always_comb begin
        active = ({1'b0, count} < duty) || (duty >= period);
        case (action)
            compact_timer_pkg::PWM_FORCE_INACTIVE: raw = 1'b0;
            compact_timer_pkg::PWM_FORCE_ACTIVE: raw = 1'b1;
            compact_timer_pkg::PWM_WAVE: raw = active;
            default: raw = 1'b0;
        endcase
        // Active high when initial_level is set, then optional invert
        level = (raw ~^ initial_level) ^ output_invert;
    end
endmodule

/* File: design/timer_comparators.sv */
`timescale 1ns/1ps
module timer_comparators (
    timer_match_if.comp m
);
    // ------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------
    logic [9:0] count_plus;

    // Period code is compared with the top three bits of count plus one,
    // whose low seven bits must be zero. The P match
    // is taken on the tick that would carry the counter onto the code's
    // multiple of 128, so a period is exactly that many ticks long.
    always_comb begin
        count_plus = m.count + 10'h001;
        m.match_a = (m.count == m.compare_a_value);
        m.match_p = (m.period_code != 3'h0) &&
            (count_plus[9:compact_timer_pkg::PERIOD_LSB] ==
            m.period_code) &&
            (count_plus[compact_timer_pkg::PERIOD_LSB-1:0] == '0);
        m.at_max = (m.count == compact_timer_pkg::COUNT_MAX);
    end
endmodule

/* File: dv/compact_timer_tb.sv */
`timescale 1ns/1ps
module compact_timer_tb;
    logic clock = 0, sys_rst = 1, timer_tick = 1, counter_on = 0;
    logic mode_select_high = 0, mode_select_low = 0, clear_select = 0;
    logic output_action_high = 0, output_action_low = 0;
    logic initial_level = 0, output_invert = 0, period_duty_swap = 0;
    logic [2:0] period_code = 0;
    logic [9:0] compare_a_value = 0, count_value, maxc = 0, held;
    logic flag_clear_a = 0, flag_clear_p = 0, pin;
    logic compare_a_flag, period_match_flag, timer_out, timer_out_enable;
    logic [1:0] act;
    logic [10:0] hi;
    int n_fail = 0, checks = 0;

    always #10 clock = ~clock;
    always @(posedge clock) if (count_value > maxc) maxc <= count_value;

    compact_timer i_dut (.clock, .sys_rst, .timer_tick, .counter_on,
        .mode_select_high, .mode_select_low, .clear_select,
        .output_action_high, .output_action_low, .initial_level,
        .output_invert, .period_duty_swap, .period_code, .compare_a_value,
        .flag_clear_a, .flag_clear_p, .compare_a_flag, .period_match_flag,
        .timer_out, .timer_out_enable, .count_value);
    pin_load i_load (.timer_out, .timer_out_enable, .pin);

    task conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    // Counter is stopped while the setup changes, as the mode bits require
    task setup(input logic [1:0] md, input logic cs, input logic [1:0] ac,
               input logic ini, inv, sw, input logic [2:0] code,
               input logic [9:0] ca);
        counter_on = 0;
        {mode_select_high, mode_select_low} = md;
        {output_action_high, output_action_low} = ac;
        clear_select = cs;
        initial_level = ini;
        output_invert = inv;
        period_duty_swap = sw;
        period_code = code;
        compare_a_value = ca;
        flag_clear_a = 1;
        flag_clear_p = 1;
        @(negedge clock);
        flag_clear_a = 0;
        flag_clear_p = 0;
        maxc = 0;
        counter_on = 1;
        @(negedge clock);
    endtask

    task wait_flag(input bit p);
        int i;
        for (i = 0; i < 2000; i++) begin
            if ((p ? period_match_flag : compare_a_flag) === 1'b1) break;
            @(negedge clock);
        end
        if (i == 2000) begin
            $display("MISMATCH flag_wait expected 1 seen 0");
            n_fail++;
            conclude();
        end
    endtask

    task pwm_case(input logic cs, input logic [1:0] ac, input logic ini,
                  inv, sw, input logic [2:0] code, input logic [9:0] ca,
                  input logic [10:0] exp, input logic [1:0] fl);
        setup(compact_timer_pkg::MODE_PWM, cs, ac, ini, inv, sw, code, ca);
        repeat (8) @(negedge clock);
        hi = 0;
        repeat (256) begin
            @(negedge clock);
            hi = hi + pin;
        end
        chk("pwm_high_cycles", exp, hi);
        chk("pwm_flags", fl, {compare_a_flag, period_match_flag});
    endtask

    initial begin
        repeat (2) @(negedge clock);
        sys_rst = 0;
        @(negedge clock);
        // ----------------------------------------------------------
        // Compare-match output: every action code from both levels
        // ----------------------------------------------------------
        for (int k = 0; k < 8; k++) begin
            act = k[1:0];
            setup(2'b00, 0, act, k[2], 0, 0, 3'h1, 10'h020);
            repeat (3) @(negedge clock);
            chk("pin_initial", k[2], timer_out);
            chk("pin_enable", 1, timer_out_enable);
            wait_flag(0);
            chk("p_before_a", 0, period_match_flag);
            repeat (3) @(negedge clock);
            chk("pin_after_a", act == 2'b00 ? k[2] : act == 2'b11 ? !k[2]
                : act[1], timer_out);
        end
        wait_flag(1);
        chk("max_count_p", 10'h07f, maxc);
        chk("both_flags", 11'h003, {compare_a_flag, period_match_flag});
        // Let the count move off zero so that holding is really seen
        repeat (20) @(negedge clock);
        counter_on = 0;
        held = count_value;
        repeat (5) @(negedge clock);
        chk("count_hold", held, count_value);
        counter_on = 1;
        repeat (3) @(negedge clock);
        chk("pin_restart", 1, timer_out);
        chk("count_restart", 11'h002, count_value);
        timer_tick = 0;
        held = count_value;
        repeat (5) @(negedge clock);
        chk("count_no_tick", held, count_value);
        timer_tick = 1;
        setup(2'b00, 1, 2'b10, 0, 0, 0, 3'h1, 10'h040);
        repeat (300) @(negedge clock);
        chk("clear_on_a", 11'h002, {compare_a_flag, period_match_flag});
        chk("max_count_a", 10'h040, maxc);
        setup(2'b00, 1, 2'b10, 0, 0, 0, 3'h1, 10'h000);
        repeat (1100) @(negedge clock);
        chk("a_zero_flag", 0, compare_a_flag);
        chk("a_zero_max", 10'h3ff, maxc);
        setup(2'b11, 0, 2'b10, 1, 0, 0, 3'h1, 10'h020);
        repeat (300) @(negedge clock);
        chk("timer_enable", 0, timer_out_enable);
        chk("timer_pin", 0, pin);
        chk("timer_flags", 11'h003, {compare_a_flag, period_match_flag});
        chk("timer_max", 10'h07f, maxc);
        // ----------------------------------------------------------
        // PWM: duty, polarity, forcing, swap and full duty
        // ----------------------------------------------------------
        pwm_case(0, 2'b10, 1, 0, 0, 3'h1, 10'h020, 11'd64, 2'b11);
        pwm_case(1, 2'b10, 1, 0, 0, 3'h1, 10'h020, 11'd64, 2'b11);
        pwm_case(0, 2'b10, 0, 0, 0, 3'h1, 10'h020, 11'd192, 2'b11);
        pwm_case(0, 2'b10, 1, 1, 0, 3'h1, 10'h020, 11'd192, 2'b11);
        pwm_case(0, 2'b10, 1, 0, 0, 3'h1, 10'h200, 11'd256, 2'b01);
        pwm_case(0, 2'b10, 1, 0, 1, 3'h1, 10'h100, 11'd128, 2'b11);
        pwm_case(0, 2'b00, 1, 0, 0, 3'h1, 10'h020, 11'd0, 2'b11);
        pwm_case(0, 2'b00, 0, 0, 0, 3'h1, 10'h020, 11'd256, 2'b11);
        pwm_case(0, 2'b01, 1, 0, 0, 3'h1, 10'h020, 11'd256, 2'b11);
        pwm_case(0, 2'b10, 1, 0, 0, 3'h2, 10'h040, 11'd64, 2'b11);
        pwm_case(0, 2'b10, 1, 0, 0, 3'h0, 10'h100, 11'd248, 2'b10);
        conclude();
    end
endmodule

/* File: dv/pin_load.sv */
`timescale 1ns/1ps
// Load on the timer pin; a pull-down means a released pin reads low
module pin_load (
    input wire logic timer_out,
    input wire logic timer_out_enable,
    output logic pin
);
    assign pin = timer_out_enable ? timer_out : 1'b0;
endmodule

/* File: include/compact_timer_pkg.sv */
package compact_timer_pkg;

    // ------------------------------------------------------------
    // Widths and codes
    // ------------------------------------------------------------
    localparam int COUNT_WIDTH = 10;
    localparam int PERIOD_WIDTH = 3;
    localparam int PERIOD_LSB = 7;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;
    localparam logic [9:0] COUNT_RESET = 10'h000;
    localparam logic [9:0] PERIOD_STEP = 10'h080;
    localparam logic [10:0] PERIOD_FULL = 11'h400;

    typedef enum logic [1:0] {
        MODE_COMPARE = 2'b00,
        MODE_UNDEF = 2'b01,
        MODE_PWM = 2'b10,
        MODE_TIMER = 2'b11
    } mode_t;

    localparam logic [1:0] ACT_NONE = 2'b00;
    localparam logic [1:0] ACT_LOW = 2'b01;
    localparam logic [1:0] ACT_HIGH = 2'b10;
    localparam logic [1:0] ACT_TOGGLE = 2'b11;

    localparam logic [1:0] PWM_FORCE_INACTIVE = 2'b00;
    localparam logic [1:0] PWM_FORCE_ACTIVE = 2'b01;
    localparam logic [1:0] PWM_WAVE = 2'b10;

    localparam logic PIN_RESET = 1'b0;

endpackage

/* File: include/timer_match_if.sv */
`timescale 1ns/1ps
interface timer_match_if;
    logic [9:0] count;
    logic [2:0] period_code;
    logic [9:0] compare_a_value;
    logic match_a;
    logic match_p;
    logic at_max;

    modport core (output count, input match_a, input match_p,
        input at_max);
    modport comp (input count, input period_code, input compare_a_value,
        output match_a, output match_p, output at_max);
    modport cfg (output period_code, output compare_a_value);
endinterface
